//--- verilog/lpt_pkg.sv
// Package: constants, register map and types for the panel timing front end
package lpt_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int CLOCK_OUTPUT_HIGH_NS = 20;
    localparam int CLOCK_OUTPUT_HIGH_CYC = (CLOCK_OUTPUT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ==========================================================
    // Register map
    localparam logic [3:0] CTRL_OFS = 4'h0;
    localparam logic [3:0] STAT_OFS = 4'h4;
    localparam int CTRL_POL_BIT = 0;
    localparam int CTRL_POS_BIT = 1;
    localparam int CTRL_FREQ_BIT = 2;
    localparam int CTRL_REV_BIT = 3;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_PHA_LSB = 8;
    localparam int CTRL_PHB_LSB = 10;
    localparam int STAT_SECOND_BIT = 0;
    localparam int STAT_REF_BIT = 1;
    localparam int STAT_DLY_LSB = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // Modes
    typedef enum logic [1:0] {
        LPT_MODE_800 = 2'b00,
        LPT_MODE_1024 = 2'b01,
        LPT_MODE_1280 = 2'b10,
        LPT_MODE_1600 = 2'b11
    } lpt_mode_t;
    typedef struct packed {
        logic [1:0] phase_b;
        logic [1:0] phase_a;
        lpt_mode_t mode;
        logic reverse_scan;
        logic clock_output_freq_sel;
        logic dev_position;
        logic ref_pulse_latch_polarity;
    } lpt_ctrl_t;
    // Pull-up defaults on the three select bits, 1024 mode, zero phase
    localparam lpt_ctrl_t CTRL_RESET = '{phase_b: 2'h0, phase_a: 2'h0, mode: LPT_MODE_1024,
        reverse_scan: 1'b0, clock_output_freq_sel: 1'b1, dev_position: 1'b1, ref_pulse_latch_polarity: 1'b1};
    typedef struct packed {
        logic [4:0] delay;
        logic ref_latched;
        logic second_device;
    } lpt_stat_t;
endpackage

//--- verilog/lpt_timing_config.sv
// Panel timing configuration front end with AXI4-Lite register access
//
// Behaviour
// - Polarity high: latch reference pulse on dot clock fall; low: on rise.
// - Two four-level phase selects give sixteen output phase settings.
// - Phase step is one dot clock, or half a dot clock in 800 mode.
// - Forward scan, 1024/1600 modes: position high is second device, low first.
// - Reverse scan swaps the meaning: position high first, low second.
// - Frequency select high: clock output at the master clock frequency.
// - Frequency select low: clock output at twice the master clock frequency.
`timescale 1ns/1ps
module lpt_timing_config
    import lpt_pkg::*;
#(
    parameter int HIST_DEPTH = 32
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // Video timing pins
    input wire logic dot_clock_in,
    input wire logic ref_timing_pulse,
    input wire logic enable_pulse_in,
    // Timing outputs
    output logic clock_output,
    output logic phased_ref_out,
    output logic enable_latched,
    output logic second_device,
    // AXI4-Lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    if (HIST_DEPTH < 31) begin : g_depth_check
        $error("HIST_DEPTH too short for the phase range");
    end

    // ==========================================================
    // Reset release
    logic rst_s1_q;
    logic rst_n_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // ==========================================================
    // Pin synchronisers
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic dot_prev_q;
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            dot_prev_q <= 1'b0;
        end else begin
            pin_s1_q <= {enable_pulse_in, ref_timing_pulse, dot_clock_in};
            pin_s2_q <= pin_s1_q;
            dot_prev_q <= pin_s2_q[0];
        end
    end
    wire dot_s = pin_s2_q[0];
    wire ref_s = pin_s2_q[1];
    wire enb_s = pin_s2_q[2];
    wire dot_rise = dot_s & ~dot_prev_q;
    wire dot_fall = ~dot_s & dot_prev_q;
    wire dot_edge = dot_rise | dot_fall;

    // ==========================================================
    // Configuration decode
    lpt_ctrl_t ctrl_q;
    wire latch_edge = ctrl_q.ref_pulse_latch_polarity ? dot_fall : dot_rise;
    wire [3:0] phase_sel = {ctrl_q.phase_b, ctrl_q.phase_a};
    wire half_step = (ctrl_q.mode == LPT_MODE_800);
    wire [4:0] delay_half = half_step ? {1'b0, phase_sel} : {phase_sel, 1'b0};
    wire pos_valid = (ctrl_q.mode == LPT_MODE_1024) || (ctrl_q.mode == LPT_MODE_1600);
    wire second_d = pos_valid & (ctrl_q.dev_position ^ ctrl_q.reverse_scan);

    // ==========================================================
    // Reference capture and phase delay line (one tap per dot half period)
    logic ref_cap_q;
    logic [HIST_DEPTH-1:0] hist_q;
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ref_cap_q <= 1'b0;
            enable_latched <= 1'b0;
            hist_q <= '0;
            phased_ref_out <= 1'b0;
            second_device <= 1'b0;
        end else begin
            if (latch_edge) begin
                ref_cap_q <= ref_s;
                enable_latched <= enb_s;
            end
            if (dot_edge) begin
                hist_q <= {hist_q[HIST_DEPTH-2:0], ref_cap_q};
            end
            phased_ref_out <= hist_q[delay_half];
            second_device <= second_d;
        end
    end

    // ==========================================================
    // Clock output: follow dot clock, or one pulse per dot edge
    logic [7:0] hi_cnt_q;
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            hi_cnt_q <= 8'h0;
            clock_output <= 1'b0;
        end else if (ctrl_q.clock_output_freq_sel) begin
            hi_cnt_q <= 8'h0;
            clock_output <= dot_s;
        end else if (dot_edge) begin
            hi_cnt_q <= 8'(CLOCK_OUTPUT_HIGH_CYC - 1);
            clock_output <= 1'b1;
        end else if (hi_cnt_q != 8'h0) begin
            hi_cnt_q <= hi_cnt_q - 8'h1;
        end else begin
            clock_output <= 1'b0;
        end
    end

    // ==========================================================
    // AXI4-Lite slave
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic aw_got_q;
    logic w_got_q;
    logic [3:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    wire aw_hs = s_axi_awvalid & s_axi_awready;
    wire w_hs = s_axi_wvalid & s_axi_wready;
    wire aw_have = aw_got_q | aw_hs;
    wire w_have = w_got_q | w_hs;
    wire [3:0] wr_addr = aw_hs ? s_axi_awaddr : awaddr_q;
    wire [31:0] wr_data = w_hs ? s_axi_wdata : wdata_q;
    wire [3:0] wr_strb = w_hs ? s_axi_wstrb : wstrb_q;
    wire wr_go = aw_have & w_have & ~s_axi_bvalid;
    wire wr_ctrl = wr_go & (wr_addr == CTRL_OFS);
    wire wr_map = (wr_addr == CTRL_OFS) || (wr_addr == STAT_OFS);
    wire [31:0] ctrl_word = {20'h0, ctrl_q.phase_b, ctrl_q.phase_a, 2'h0, ctrl_q.mode,
                             ctrl_q.reverse_scan, ctrl_q.clock_output_freq_sel, ctrl_q.dev_position,
                             ctrl_q.ref_pulse_latch_polarity};
    wire [31:0] ctrl_new = merge_strb(ctrl_word, wr_data, wr_strb);
    lpt_stat_t stat_w;
    assign stat_w = '{delay: delay_half, ref_latched: ref_cap_q, second_device: second_device};
    wire ar_hs = s_axi_arvalid & s_axi_arready;
    wire rd_ctrl = (s_axi_araddr == CTRL_OFS);
    wire rd_stat = (s_axi_araddr == STAT_OFS);
    wire [31:0] rd_word = rd_ctrl ? ctrl_word : (rd_stat ? {25'h0, stat_w} : 32'h0);

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ctrl_q <= CTRL_RESET;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_hs) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_hs) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
                s_axi_awready <= 1'b0;
                s_axi_wready <= 1'b0;
            end else begin
                aw_got_q <= aw_have;
                w_got_q <= w_have;
                s_axi_awready <= ~aw_have & ~s_axi_bvalid;
                s_axi_wready <= ~w_have & ~s_axi_bvalid;
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                    s_axi_awready <= 1'b1;
                    s_axi_wready <= 1'b1;
                end
            end
            if (wr_ctrl) begin
                ctrl_q <= '{phase_b: ctrl_new[CTRL_PHB_LSB +: 2], phase_a: ctrl_new[CTRL_PHA_LSB +: 2],
                    mode: lpt_mode_t'(ctrl_new[CTRL_MODE_LSB +: 2]), reverse_scan: ctrl_new[CTRL_REV_BIT],
                    clock_output_freq_sel: ctrl_new[CTRL_FREQ_BIT], dev_position: ctrl_new[CTRL_POS_BIT],
                    ref_pulse_latch_polarity: ctrl_new[CTRL_POL_BIT]};
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (ar_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= (rd_ctrl | rd_stat) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else begin
            s_axi_arready <= ~s_axi_rvalid;
        end
    end

    // ==========================================================
    // Checks
    sequence s_rise_pol;
        ctrl_q.ref_pulse_latch_polarity == 1'b0 && dot_rise;
    endsequence
    sequence s_fall_pol;
        ctrl_q.ref_pulse_latch_polarity == 1'b1 && dot_fall;
    endsequence

    chk_rise_latch_ref: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        s_rise_pol |=> ref_cap_q == $past(ref_s)) else $error("ref not latched on rise");
    chk_fall_latch_ref: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        s_fall_pol |=> ref_cap_q == $past(ref_s)) else $error("ref not latched on fall");
    chk_hold_no_edge: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        !latch_edge |=> $stable(ref_cap_q)) else $error("ref changed off latch edge");
    chk_phase_sixteen: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        delay_half == (half_step ? 5'(phase_sel) : 5'(phase_sel) * 5'd2)) else $error("phase decode wrong");
    chk_phase_step_out: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        1'b1 |=> phased_ref_out == $past(hist_q[delay_half])) else $error("phased output wrong tap");
    chk_forward_position: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (rst_n_q && pos_valid && !ctrl_q.reverse_scan) [*2] |-> second_device == $past(ctrl_q.dev_position))
        else $error("forward position wrong");
    chk_reverse_position: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (rst_n_q && pos_valid && ctrl_q.reverse_scan) [*2] |-> second_device == !$past(ctrl_q.dev_position))
        else $error("reverse position wrong");
    chk_same_freq_out: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        ctrl_q.clock_output_freq_sel [*2] |-> clock_output == $past(dot_s)) else $error("clock output not following");
    chk_double_pulse: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        (!ctrl_q.clock_output_freq_sel && dot_edge) ##1 !ctrl_q.clock_output_freq_sel |-> clock_output)
        else $error("no clock pulse on dot edge");
    chk_reset_pullup: assert property (@(posedge ref_clk)
        $rose(rst_n_q) |-> ctrl_q.ref_pulse_latch_polarity && ctrl_q.dev_position && ctrl_q.clock_output_freq_sel)
        else $error("select defaults not high");
    chk_write_resp: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        wr_go |=> s_axi_bvalid) else $error("write response missing");
    chk_enable_latch: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        latch_edge |=> enable_latched == $past(enb_s)) else $error("enable not latched with ref");
    chk_pos_other_mode: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        !pos_valid |=> !second_device) else $error("position used outside its modes");
    chk_pulse_single: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        !ctrl_q.clock_output_freq_sel && clock_output && !dot_edge |=> !clock_output)
        else $error("clock pulse too long");
    chk_read_resp: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        ar_hs |=> s_axi_rvalid)
        else $error("read response missing");
    chk_write_hold: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_read_hold: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read response dropped");
    chk_ready_while_pending: assert property (@(posedge ref_clk) disable iff (!rst_n_q)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready while response pending");
endmodule

//--- test/lpt_video_src.sv
// Video timing source model: dot clock, reference pulse and enable pulse
`timescale 1ns/1ps
module lpt_video_src #(
    parameter int QUARTER_NS = 50
) (
    // Video timing pins
    output logic dot_clock_in,
    output logic ref_timing_pulse,
    output logic enable_pulse_in
);
    // ==========================================================
    // Free-running dot clock, pulses placed mid half-period
    initial begin
        dot_clock_in = 1'b0;
        ref_timing_pulse = 1'b0;
        enable_pulse_in = 1'b1;
        // Offset keeps pin changes off the sampling clock edges
        #3;
        forever begin
            dot_clock_in = 1'b1;
            #(QUARTER_NS);
            // Edges a quarter period from any latch edge
            ref_timing_pulse = 1'b1;
            enable_pulse_in = 1'b0;
            #(QUARTER_NS);
            dot_clock_in = 1'b0;
            #(QUARTER_NS);
            ref_timing_pulse = 1'b0;
            enable_pulse_in = 1'b1;
            #(QUARTER_NS);
        end
    end
endmodule

//--- test/lpt_timing_config_tb.sv
// Testbench for the panel timing configuration front end
`timescale 1ns/1ps
module lpt_timing_config_tb
    import lpt_pkg::*;
;
    logic ref_clk, reset_n, dot_clock_in, ref_timing_pulse, enable_pulse_in;
    logic clock_output, phased_ref_out, enable_latched, second_device;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, prev;
    int bad_count, n_tests, cycles, cnt, ex;
    // ==========================================================
    // Design and video source
    lpt_timing_config dut (.ref_clk, .reset_n, .dot_clock_in, .ref_timing_pulse, .enable_pulse_in,
        .clock_output, .phased_ref_out, .enable_latched, .second_device, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    lpt_video_src src (.dot_clock_in, .ref_timing_pulse, .enable_pulse_in);
    // ==========================================================
    // Clock and watchdog
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            bad_count++;
            final_report();
        end
    end
    // ==========================================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        axi_rd(a, rd, rs);
        check(rd, d);
        check(rs, r);
    endtask
    task automatic set_ctrl(input logic [31:0] v);
        axi_wr(CTRL_OFS, v, rs);
        check(rs, RESP_OKAY);
    endtask
    function automatic logic [31:0] cv(logic pol, logic pos, logic fs, logic rev, logic [1:0] md, logic [3:0] ph);
        return {20'h0, ph, 2'h0, md, rev, fs, pos, pol};
    endfunction
    task final_report;
        if (bad_count == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        reset_n = 1'b0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'b1;
        repeat (40) @(posedge ref_clk);
        rd_chk(CTRL_OFS, 32'h17, RESP_OKAY);
        rd_chk(STAT_OFS, 32'h3, RESP_OKAY);
        check(second_device, 1'b1);
        rd_chk(4'h8, 32'h0, RESP_SLVERR);
        axi_wr(4'h8, 32'hffff_ffff, rs);
        check(rs, RESP_SLVERR);
        axi_wr(STAT_OFS, 32'hffff_ffff, rs);
        check(rs, RESP_OKAY);
        rd_chk(CTRL_OFS, 32'h17, RESP_OKAY);
        // Device position against mode and scan direction
        for (int m = 0; m < 4; m++) for (int v = 0; v < 2; v++) for (int p = 0; p < 2; p++) begin
            ex = (m == 1 || m == 3) ? (p ^ v) : 0;
            set_ctrl(cv(1'b1, p[0], 1'b1, v[0], m[1:0], 4'h0));
            axi_rd(STAT_OFS, rd, rs);
            check(rd[STAT_SECOND_BIT], ex);
            check(second_device, ex);
        end
        // Phase settings in every mode
        for (int m = 0; m < 4; m++) for (int ph = 0; ph < 16; ph++) begin
            set_ctrl(cv(1'b1, 1'b1, 1'b1, 1'b0, m[1:0], ph[3:0]));
            axi_rd(STAT_OFS, rd, rs);
            check(rd[STAT_DLY_LSB +: 5], (m == 0) ? ph : ph * 2);
        end
        // Latch edge selection
        for (int pol = 0; pol < 2; pol++) begin
            set_ctrl(cv(pol[0], 1'b1, 1'b1, 1'b0, 2'h1, 4'h0));
            repeat (40) @(posedge ref_clk);
            axi_rd(STAT_OFS, rd, rs);
            check(rd[STAT_REF_BIT], pol);
            check(phased_ref_out, pol);
            check(enable_latched, !pol);
        end
        // Clock output frequency, 20 dot periods per window
        for (int fs = 1; fs >= 0; fs--) begin
            set_ctrl(cv(1'b1, 1'b1, fs[0], 1'b0, 2'h1, 4'h0));
            repeat (20) @(posedge ref_clk);
            cnt = 0;
            prev = clock_output;
            repeat (200) begin
                @(posedge ref_clk);
                if (prev === 1'b0 && clock_output === 1'b1) cnt++;
                prev = clock_output;
            end
            ex = fs ? 20 : 40;
            check(cnt >= ex - 1 && cnt <= ex + 1, 1'b1);
        end
        final_report();
    end
endmodule
